// file: hw/sre_smbus_slave.sv
// Purpose: smbus slave giving byte and block access to ram and nv memory
// Assumes: scl_clk and scl_in are the same scl wire; rstn asynchronous
// Notes:   byte engine runs on scl, timing and framing on core_clk
`include "sre_defines.svh"
`default_nettype none
module sre_smbus_slave import sre_pkg::*; #(
  parameter int unsigned PROG_CYCLES  = `SRE_T_PROG_US * `SRE_CLK_MHZ,
  parameter int unsigned ERASE_CYCLES = `SRE_T_ERASE_MS * `SRE_US_PER_MS * `SRE_CLK_MHZ
) (
  input  wire logic core_clk,            // core clock
  input  wire logic rstn,                // async reset, active low
  input  wire logic scl_clk,             // scl as link clock
  input  wire logic scl_in,              // scl level for framing
  input  wire logic sda_in,              // sda level
  output logic      sda_out,             // sda drive value
  output logic      sda_oe,              // sda pulled low
  output logic      scl_out,             // scl drive value
  output logic      scl_oe,              // scl held low
  input  wire logic addr_select_hi_pin,  // slave address bit 1
  input  wire logic addr_select_lo_pin,  // slave address bit 0
  output logic      nv_busy              // program or erase running
);
  // ----------------------------------------------------------
  // core domain: framing, stretch and erase timers
  // ----------------------------------------------------------
  localparam logic [22:0] PROG_LOAD  = 23'(PROG_CYCLES - 1);
  localparam logic [22:0] ERASE_LOAD = 23'(ERASE_CYCLES - 1);

  logic        scl_s1_q, scl_s2_q, scl_p_q;  // scl synchroniser
  logic        sda_s1_q, sda_s2_q, sda_p_q;  // sda synchroniser
  logic        prg_s1_q, prg_s2_q, prg_p_q;  // program toggle sync
  logic        ers_s1_q, ers_s2_q, ers_p_q;  // erase toggle sync
  logic        frame_q, frame_d;             // inside a frame
  logic        eng_rst_n_q, eng_rst_n_d;     // link engine reset
  sre_str_e    str_q, str_d;                 // stretch state
  logic [22:0] pcnt_q, pcnt_d;               // program timer
  logic        busy_q, busy_d;               // erase running
  logic [22:0] ecnt_q, ecnt_d;               // erase timer
  logic        scl_oe_d, nv_busy_d;          // output next values
  logic        start_det, stop_det;          // bus conditions
  logic        prg_evt, ers_evt;             // link events
  logic        prg_tgl_q, prg_tgl_d;         // program event toggle
  logic        ers_tgl_q, ers_tgl_d;         // erase event toggle

  assign start_det = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  assign stop_det  = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
  assign prg_evt   = prg_s2_q ^ prg_p_q;
  assign ers_evt   = ers_s2_q ^ ers_p_q;
  assign sda_out   = 1'b0;
  assign scl_out   = 1'b0;

  // next state of framing and timers
  always_comb begin
    frame_d = start_det ? 1'b1 : (stop_det ? 1'b0 : frame_q);
    eng_rst_n_d = frame_d & ~start_det;  // pulse low on every start
    str_d = str_q;
    pcnt_d = pcnt_q;
    busy_d = busy_q;
    ecnt_d = ecnt_q;
    case (str_q)
      ST_IDLE: begin
        if (prg_evt) str_d = ST_WAIT_LOW;
      end
      ST_WAIT_LOW: begin  // grab scl only while low, no false edge
        if (!scl_s2_q) begin
          str_d = ST_HOLD;
          pcnt_d = PROG_LOAD;
        end
      end
      ST_HOLD: begin
        if (pcnt_q == '0) str_d = ST_IDLE;
        else pcnt_d = pcnt_q - 23'h00_0001;
      end
      default: str_d = ST_IDLE;
    endcase
    if (ers_evt) begin  // erase starts the busy window
      busy_d = 1'b1;
      ecnt_d = ERASE_LOAD;
    end else if (busy_q) begin
      if (ecnt_q == '0) busy_d = 1'b0;
      else ecnt_d = ecnt_q - 23'h00_0001;
    end
    scl_oe_d = (str_d == ST_HOLD);
    nv_busy_d = busy_d | (str_d != ST_IDLE);
  end

  // core registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {scl_s1_q, scl_s2_q, scl_p_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_p_q} <= 3'h7;
      {prg_s1_q, prg_s2_q, prg_p_q} <= 3'h0;
      {ers_s1_q, ers_s2_q, ers_p_q} <= 3'h0;
      frame_q     <= 1'b0;
      eng_rst_n_q <= 1'b0;
      str_q       <= ST_IDLE;
      pcnt_q      <= '0;
      busy_q      <= 1'b0;
      ecnt_q      <= '0;
      scl_oe      <= 1'b0;
      nv_busy     <= 1'b0;
    end else begin
      {scl_s1_q, scl_s2_q, scl_p_q} <= {scl_in, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_p_q} <= {sda_in, sda_s1_q, sda_s2_q};
      {prg_s1_q, prg_s2_q, prg_p_q} <= {prg_tgl_q, prg_s1_q, prg_s2_q};
      {ers_s1_q, ers_s2_q, ers_p_q} <= {ers_tgl_q, ers_s1_q, ers_s2_q};
      frame_q     <= frame_d;
      eng_rst_n_q <= eng_rst_n_d;
      str_q       <= str_d;
      pcnt_q      <= pcnt_d;
      busy_q      <= busy_d;
      ecnt_q      <= ecnt_d;
      scl_oe      <= scl_oe_d;
      nv_busy     <= nv_busy_d;
    end
  end

  // ----------------------------------------------------------
  // link domain: byte engine and memories
  // ----------------------------------------------------------
  sre_phase_e phase_q, phase_d;        // transaction phase
  logic [3:0] bitcnt_q, bitcnt_d;      // bit within byte, 8 = ack
  logic [6:0] sh_q, sh_d;              // received bits
  logic       ack_q, ack_d;            // ack the byte just taken
  logic [5:0] widx_q, widx_d;          // data byte index, writes
  logic [5:0] rd_idx_q, rd_idx_d;      // byte index, reads
  sre_byte_t  cmd_q, cmd_d;            // command of this frame
  sre_byte_t  bcnt_q, bcnt_d;          // block write count
  logic       blkrd_q, blkrd_d;        // read is a block read
  sre_byte_t  tx_q, tx_d;              // byte being sent
  logic [15:0] ptr_q, ptr_d;           // stored address pointer
  sre_byte_t  last_cmd_q, last_cmd_d;  // command of last write
  sre_byte_t  crc_q, crc_d;            // running packet check
  logic       ahi_s1_q, ahi_s2_q;      // address pin syncs
  logic       alo_s1_q, alo_s2_q;
  logic       bsy_s1_q, bsy_s2_q;      // erase busy sync
  sre_byte_t  ram_q [`SRE_RAM_WORDS];  // volatile registers
  sre_byte_t  nv_q  [`SRE_NV_WORDS];   // nonvolatile bytes
  logic       wr_en, ers_en, load;     // engine strobes
  logic [15:0] wr_addr;                // write address
  sre_byte_t  rx_byte, rd_byte;        // byte in, byte at pointer
  sre_byte_t  crc_seed, crc_byte, crc_nx;
  logic       crc_upd, ram_sel, nv_sel, sda_oe_d;
  logic [6:0] my_addr;                 // own slave address

  assign rx_byte = {sh_q, sda_in};
  assign my_addr = {`SRE_ADDR_HI, ahi_s2_q, alo_s2_q};
  assign ram_sel = (ptr_q[15:8] == 8'h00) && (ptr_q[7:0] <= `SRE_RAM_TOP);
  assign nv_sel  = (ptr_q[15:10] == `SRE_NV_TAG);
  assign rd_byte = ram_sel ? ram_q[ptr_q[7:0]] : (nv_sel ? nv_q[ptr_q[9:0]] : 8'h00);

  sre_crc8 u_crc (
    .crc_in  (crc_seed),
    .data_in (crc_byte),
    .crc_out (crc_nx)
  );

  // byte engine next state
  always_comb begin
    phase_d = phase_q;
    bitcnt_d = bitcnt_q + 4'h1;
    sh_d = {sh_q[5:0], sda_in};
    ack_d = ack_q;
    widx_d = widx_q;
    rd_idx_d = rd_idx_q;
    cmd_d = cmd_q;
    bcnt_d = bcnt_q;
    blkrd_d = blkrd_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    last_cmd_d = last_cmd_q;
    prg_tgl_d = prg_tgl_q;
    ers_tgl_d = ers_tgl_q;
    wr_en = 1'b0;
    wr_addr = ptr_q;
    ers_en = 1'b0;
    load = 1'b0;
    crc_upd = 1'b0;
    crc_seed = crc_q;
    crc_byte = rx_byte;
    if (bitcnt_q == `SRE_BIT_LAST) begin  // eighth bit: byte complete
      ack_d = 1'b1;
      crc_upd = 1'b1;
      case (phase_q)
        PH_ADDR: begin
          crc_seed = 8'h00;
          if (rx_byte[7:1] != my_addr || bsy_s2_q) begin
            ack_d = 1'b0;
            phase_d = PH_IGNORE;
          end else if (rx_byte[0]) begin
            phase_d = PH_RSTART;
            blkrd_d = (last_cmd_q == `SRE_CMD_BLK_RD);
            if (blkrd_d) crc_seed = crc_q;  // block read check spans restart
          end else begin
            phase_d = PH_CMD;
          end
        end
        PH_CMD: begin
          cmd_d = rx_byte;
          last_cmd_d = rx_byte;
          widx_d = 6'h00;
          phase_d = PH_DATA;
          if (rx_byte <= `SRE_RAM_TOP) ptr_d = {8'h00, rx_byte};
          if (rx_byte == `SRE_CMD_ERASE && nv_sel && ram_q[`SRE_UPD_CFG][`SRE_UPD_ERASE_BIT]) begin
            ers_en = 1'b1;
            ers_tgl_d = ~ers_tgl_q;
          end
        end
        PH_DATA: begin  // the command byte picks the form
          widx_d = (widx_q == 6'h3F) ? widx_q : widx_q + 6'h01;
          if (cmd_q <= `SRE_RAM_TOP) begin
            if (widx_q == 6'h00) begin
              wr_en = 1'b1;
              wr_addr = {8'h00, cmd_q};
            end else if (widx_q == 6'h01) ack_d = (rx_byte == crc_q);
          end else if (cmd_q >= `SRE_NV_LO && cmd_q <= `SRE_NV_HI) begin
            if (widx_q == 6'h00) ptr_d = {cmd_q, rx_byte};
            else if (widx_q == 6'h01) begin
              wr_en = 1'b1;
              prg_tgl_d = ~prg_tgl_q;
            end else if (widx_q == 6'h02) ack_d = (rx_byte == crc_q);
          end else if (cmd_q == `SRE_CMD_BLK_WR) begin
            if (widx_q == 6'h00) bcnt_d = rx_byte;
            else if ({2'b00, widx_q} <= bcnt_q) begin
              wr_en = 1'b1;
              ptr_d = ptr_q + 16'h0001;
              if (nv_sel) prg_tgl_d = ~prg_tgl_q;
            end else if ({2'b00, widx_q} == 8'(bcnt_q + 8'h01)) begin
              ack_d = (rx_byte == crc_q);
            end
          end
        end
        default: begin  // reads and ignored frames
          ack_d = 1'b0;
          crc_upd = 1'b0;
        end
      endcase
    end else if (bitcnt_q == `SRE_BIT_ACK) begin  // ninth clock
      bitcnt_d = 4'h0;
      case (phase_q)
        PH_RSTART: begin
          phase_d = PH_READ;
          load = 1'b1;
        end
        PH_READ: begin
          if (sda_in) phase_d = PH_IGNORE;
          else load = 1'b1;
        end
        default: begin
          if (!ack_q) phase_d = PH_IGNORE;
        end
      endcase
      if (load) begin
        rd_idx_d = (rd_idx_q == 6'h3F) ? rd_idx_q : rd_idx_q + 6'h01;
        if (!blkrd_q) tx_d = rd_byte;
        else if (rd_idx_q == 6'h00) tx_d = `SRE_BLK_COUNT;
        else if (rd_idx_q <= `SRE_BLK_LAST) begin
          tx_d = rd_byte;
          ptr_d = ptr_q + 16'h0001;
        end else tx_d = crc_q;
        crc_upd = blkrd_q && (rd_idx_q <= `SRE_BLK_LAST);
        crc_byte = tx_d;
      end
    end
    crc_d = crc_upd ? crc_nx : crc_q;
  end

  // engine registers, cleared at every start and stop
  always_ff @(posedge scl_clk or negedge eng_rst_n_q) begin
    if (!eng_rst_n_q) begin
      phase_q  <= PH_ADDR;
      bitcnt_q <= 4'h0;
      sh_q     <= 7'h00;
      ack_q    <= 1'b0;
      widx_q   <= 6'h00;
      rd_idx_q <= 6'h00;
      cmd_q    <= 8'h00;
      bcnt_q   <= 8'h00;
      blkrd_q  <= 1'b0;
      tx_q     <= 8'h00;
    end else begin
      phase_q  <= phase_d;
      bitcnt_q <= bitcnt_d;
      sh_q     <= sh_d;
      ack_q    <= ack_d;
      widx_q   <= widx_d;
      rd_idx_q <= rd_idx_d;
      cmd_q    <= cmd_d;
      bcnt_q   <= bcnt_d;
      blkrd_q  <= blkrd_d;
      tx_q     <= tx_d;
    end
  end

  // state that outlives a frame
  always_ff @(posedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      ptr_q      <= 16'h0000;
      last_cmd_q <= 8'h00;
      crc_q      <= 8'h00;
      prg_tgl_q  <= 1'b0;
      ers_tgl_q  <= 1'b0;
      {ahi_s1_q, ahi_s2_q} <= 2'h0;
      {alo_s1_q, alo_s2_q} <= 2'h0;
      {bsy_s1_q, bsy_s2_q} <= 2'h0;
    end else begin
      ptr_q      <= ptr_d;
      last_cmd_q <= last_cmd_d;
      crc_q      <= crc_d;
      prg_tgl_q  <= prg_tgl_d;
      ers_tgl_q  <= ers_tgl_d;
      {ahi_s1_q, ahi_s2_q} <= {addr_select_hi_pin, ahi_s1_q};
      {alo_s1_q, alo_s2_q} <= {addr_select_lo_pin, alo_s1_q};
      {bsy_s1_q, bsy_s2_q} <= {busy_q, bsy_s1_q};
    end
  end

  // sda drive: ack on ninth clock, data bits while reading
  always_comb begin
    sda_oe_d = ((bitcnt_q == `SRE_BIT_ACK) && ack_q && phase_q != PH_READ)
             || (phase_q == PH_READ && bitcnt_q < `SRE_BIT_ACK && !tx_q[~bitcnt_q[2:0]]);
  end

  always_ff @(negedge scl_clk or negedge eng_rst_n_q) begin
    if (!eng_rst_n_q) sda_oe <= 1'b0;
    else sda_oe <= sda_oe_d;
  end

  // volatile registers, one write port
  for (genvar i = 0; i < `SRE_RAM_WORDS; i++) begin : g_ram
    always_ff @(posedge scl_clk or negedge rstn) begin
      if (!rstn) ram_q[i] <= 8'h00;
      else if (wr_en && wr_addr == {8'h00, 8'(i)}) ram_q[i] <= rx_byte;
    end
  end

  // nonvolatile bytes: byte program or whole page erase
  for (genvar i = 0; i < `SRE_NV_WORDS; i++) begin : g_nv
    always_ff @(posedge scl_clk or negedge rstn) begin
      if (!rstn) nv_q[i] <= `SRE_ERASED;
      else if (ers_en && ptr_q[9:`SRE_PAGE_LSB] == 5'(i >> `SRE_PAGE_LSB)) nv_q[i] <= `SRE_ERASED;
      else if (wr_en && wr_addr == {`SRE_NV_TAG, 10'(i)}) nv_q[i] <= rx_byte;
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  property p_ram_write;
    @(posedge scl_clk) disable iff (!eng_rst_n_q)
      phase_q == PH_DATA && bitcnt_q == `SRE_BIT_LAST && widx_q == 6'h00 && cmd_q <= `SRE_RAM_TOP
      |=> ram_q[$past(cmd_q)] == $past(rx_byte);
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("ram byte not stored");

  property p_nv_ptr;
    @(posedge scl_clk) disable iff (!eng_rst_n_q)
      phase_q == PH_DATA && bitcnt_q == `SRE_BIT_LAST && widx_q == 6'h00
      && cmd_q >= `SRE_NV_LO && cmd_q <= `SRE_NV_HI |=> ptr_q == {$past(cmd_q), $past(rx_byte)};
  endproperty
  a_nv_ptr: assert property (p_nv_ptr) else $error("nv pointer not latched");

  property p_nv_prog;
    @(posedge scl_clk) disable iff (!eng_rst_n_q)
      phase_q == PH_DATA && bitcnt_q == `SRE_BIT_LAST && widx_q == 6'h01
      && cmd_q >= `SRE_NV_LO && cmd_q <= `SRE_NV_HI
      |=> nv_q[$past(ptr_q[9:0])] == $past(rx_byte) && prg_tgl_q != $past(prg_tgl_q);
  endproperty
  a_nv_prog: assert property (p_nv_prog) else $error("nv byte not programmed");

  property p_cmd_ack;
    @(posedge scl_clk) disable iff (!eng_rst_n_q)
      phase_q == PH_CMD && bitcnt_q == `SRE_BIT_LAST |=> ack_q ##1 phase_q == PH_DATA;
  endproperty
  a_cmd_ack: assert property (p_cmd_ack) else $error("command byte not acked");

  property p_addr_miss;
    @(posedge scl_clk) disable iff (!eng_rst_n_q)
      phase_q == PH_ADDR && bitcnt_q == `SRE_BIT_LAST && (rx_byte[7:1] != my_addr || bsy_s2_q)
      |=> !ack_q && phase_q == PH_IGNORE;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign or busy address acked");

  property p_blk_count;
    @(posedge scl_clk) disable iff (!eng_rst_n_q)
      phase_q == PH_RSTART && bitcnt_q == `SRE_BIT_ACK && blkrd_q |=> tx_q == `SRE_BLK_COUNT;
  endproperty
  a_blk_count: assert property (p_blk_count) else $error("wrong block count byte");

  property p_rd_step;
    @(posedge scl_clk) disable iff (!eng_rst_n_q)
      phase_q == PH_READ && bitcnt_q == `SRE_BIT_ACK && !sda_in && blkrd_q
      && rd_idx_q != 6'h00 && rd_idx_q <= `SRE_BLK_LAST |=> ptr_q == $past(ptr_q) + 16'h0001;
  endproperty
  a_rd_step: assert property (p_rd_step) else $error("pointer did not advance");

  property p_stretch;
    @(posedge core_clk) disable iff (!rstn)
      str_q == ST_WAIT_LOW && !scl_s2_q |=> scl_oe ##1 scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("scl not held for programming");

  property p_release;
    @(posedge core_clk) disable iff (!rstn)
      $fell(scl_oe) |-> $past(pcnt_q) == '0 && str_q == ST_IDLE;
  endproperty
  a_release: assert property (p_release) else $error("scl released early");

  c_blk_pec:  cover property (@(posedge scl_clk) phase_q == PH_READ && rd_idx_q == 6'h22);
  c_blk_wr:   cover property (@(posedge scl_clk) wr_en && cmd_q == `SRE_CMD_BLK_WR && nv_sel);
  c_erase:    cover property (@(posedge scl_clk) ers_en);
  c_hold:     cover property (@(posedge core_clk) str_q == ST_HOLD);
endmodule : sre_smbus_slave
`default_nettype wire

// file: hw/sre_defines.svh
// Purpose: named constants of the smbus ram/nv access slave
// Assumes: core clock of 250 MHz
// Notes:   included by bare name, guarded against double inclusion
`ifndef SRE_DEFINES_SVH
`define SRE_DEFINES_SVH
`define SRE_ADDR_HI       5'h0D   // fixed upper slave address bits
`define SRE_RAM_TOP       8'hDF   // last volatile address
`define SRE_RAM_WORDS     224     // volatile bytes
`define SRE_NV_WORDS      1024    // nonvolatile bytes
`define SRE_NV_LO         8'hF8   // first nv high byte
`define SRE_NV_HI         8'hFB   // last nv high byte
`define SRE_NV_TAG        6'h3E   // address bits 15:10 of the nv window
`define SRE_PAGE_LSB      5       // low address bits inside one page
`define SRE_CMD_BLK_WR    8'hFC   // block write command
`define SRE_CMD_BLK_RD    8'hFD   // block read command
`define SRE_CMD_ERASE     8'hFE   // page erase command
`define SRE_BLK_COUNT     8'h20   // count byte of a block read
`define SRE_BLK_LAST      6'h20   // last data index of a block read
`define SRE_UPD_CFG       8'h90   // update config register address
`define SRE_UPD_ERASE_BIT 2       // erase enable bit in it
`define SRE_ERASED        8'hFF   // value of an erased nv byte
`define SRE_CRC_POLY      8'h07   // x^8 + x^2 + x + 1
`define SRE_BIT_LAST      4'h7    // bit count of the eighth data bit
`define SRE_BIT_ACK       4'h8    // bit count of the ninth clock
`define SRE_CLK_MHZ       250     // core clock rate
`define SRE_US_PER_MS     1000    // microseconds in a millisecond
`define SRE_T_PROG_US     250     // nv byte program time
`define SRE_T_ERASE_MS    20      // nv page erase time
`endif

// file: hw/sre_pkg.sv
// Purpose: types of the smbus ram/nv access slave
// Assumes: nothing beyond the defines header
// Notes:   constants live in sre_defines.svh
`default_nettype none
package sre_pkg;
  // --------------------------------------------------------
  // link engine phase and stretch states
  // --------------------------------------------------------
  typedef enum logic [2:0] {PH_ADDR, PH_CMD, PH_DATA, PH_RSTART, PH_READ, PH_IGNORE} sre_phase_e;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_LOW, ST_HOLD} sre_str_e;
  typedef logic [7:0] sre_byte_t;  // one bus byte
endpackage : sre_pkg
`default_nettype wire

// file: hw/sre_crc8.sv
// Purpose: folds one byte into a running crc-8 packet check
// Assumes: msb first, zero seed at frame start
// Notes:   purely combinational
`include "sre_defines.svh"
`default_nettype none
module sre_crc8 import sre_pkg::*; (
  input  wire logic [7:0] crc_in,   // running check value
  input  wire logic [7:0] data_in,  // byte to fold in
  output logic      [7:0] crc_out   // updated check value
);
  // eight shift steps of the generator
  always_comb begin
    logic [7:0] c;
    c = crc_in ^ data_in;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `SRE_CRC_POLY) : (c << 1);
    end
    crc_out = c;
  end
endmodule : sre_crc8
`default_nettype wire

// file: dv/sre_host.sv
// Purpose: smbus host model that drives the slave's bus
// Assumes: 64 ns bit period, pull-ups on both wires
// Notes:   scl stands high between frames
`default_nettype none
module sre_host (
  input  wire logic scl,      // bus clock wire
  input  wire logic sda,      // bus data wire
  output logic      scl_low,  // host pulls scl
  output logic      sda_low   // host pulls sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // one bit, scl low on entry and exit; waits out a stretch
  task automatic bit_io(input logic b, output logic s);
    int n;
    n = 0;
    sda_low = !b;
    #24 scl_low = 1'b0;
    while (scl !== 1'b1 && n < 9999) begin
      #4 n++;
    end
    #16 s = sda;
    #16 scl_low = 1'b1;
    #8;
  endtask : bit_io
  // start, also a repeated start in mid-frame
  task automatic start_c();
    sda_low = 1'b0;
    #24 scl_low = 1'b0;
    #32 sda_low = 1'b1;
    #32 scl_low = 1'b1;
    #8;
  endtask : start_c
  // stop, leaves both wires released
  task automatic stop_c();
    sda_low = 1'b1;
    #24 scl_low = 1'b0;
    #32 sda_low = 1'b0;
    #32;
  endtask : stop_c
  // byte out, ninth clock returns the slave's ack
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask : wr_byte
  // byte in, msb first, then the host's ack or nack
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(!mack, s);
  endtask : rd_byte
endmodule : sre_host
`default_nettype wire

// file: dv/testbench.sv
// Purpose: self-checking bench of the smbus ram/nv slave
// Assumes: host model sre_host, short program and erase counts
// Notes:   address pins tied high/low, slave address 0x36
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rstn, sda_oe, scl_oe, nv_busy, h_scl, h_sda, ack, sda_o, scl_o;
  logic held = 1'b0;               // stretch seen
  wire  logic scl = !(scl_oe | h_scl);  // pull-up wire
  wire  logic sda = !(sda_oe | h_sda);  // pull-up wire
  int miscompares, checks_done, cycles;
  logic [7:0] rd, crc, e;
  sre_host u_host (.scl(scl), .sda(sda), .scl_low(h_scl), .sda_low(h_sda));
  sre_smbus_slave #(.PROG_CYCLES(20), .ERASE_CYCLES(400)) u_dut (
    .core_clk(core_clk), .rstn(rstn), .scl_clk(scl), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe(sda_oe), .scl_out(scl_o), .scl_oe(scl_oe),
    .addr_select_hi_pin(1'b1), .addr_select_lo_pin(1'b0), .nv_busy(nv_busy));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // hang limit and stretch watch
  always @(posedge core_clk) begin
    cycles++;
    held <= held | scl_oe;
    if (cycles == 60000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic check(input string what, input logic [7:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic logic [7:0] crc8(input logic [7:0] c, d);
    c = c ^ d;
    for (int i = 0; i < 8; i++) c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
    return c;
  endfunction : crc8
  // write frame, every byte must be acked
  task automatic frame(input logic [7:0] b[$]);
    u_host.start_c();
    u_host.wr_byte(8'h6C, ack);
    check("addr ack", 1, ack);
    foreach (b[i]) begin
      u_host.wr_byte(b[i], ack);
      check("data ack", 1, ack);
    end
    u_host.stop_c();
  endtask : frame
  task automatic rx(input logic [7:0] exp);
    u_host.start_c();
    u_host.wr_byte(8'h6D, ack);
    u_host.rd_byte(1'b0, rd);
    u_host.stop_c();
    check("rx byte", exp, rd);
  endtask : rx
  task automatic t_addr();
    u_host.start_c();
    u_host.wr_byte(8'h6E, ack);
    u_host.stop_c();
    check("other addr ack", 0, ack);
    check("drive values", 0, {sda_o, scl_o});
  endtask : t_addr
  task automatic t_block();
    frame('{8'h10});
    frame('{8'hFC, 8'h02, 8'hA5, 8'h3C});
    frame('{8'h12, 8'h77});
    frame('{8'h10});
    u_host.start_c();
    u_host.wr_byte(8'h6C, ack);
    u_host.wr_byte(8'hFD, ack);
    u_host.start_c();
    u_host.wr_byte(8'h6D, ack);
    check("read addr ack", 1, ack);
    u_host.rd_byte(1'b1, rd);
    check("count", 8'h20, rd);
    crc = crc8(crc8(crc8(crc8(8'h00, 8'h6C), 8'hFD), 8'h6D), 8'h20);
    for (int i = 0; i < 32; i++) begin
      e = i == 0 ? 8'hA5 : i == 1 ? 8'h3C : i == 2 ? 8'h77 : 8'h00;
      u_host.rd_byte(1'b1, rd);
      check("block byte", e, rd);
      crc = crc8(crc, e);
    end
    u_host.rd_byte(1'b0, rd);
    check("check byte", crc, rd);
    u_host.stop_c();
  endtask : t_block
  // write byte with check byte: good one acked, bad one refused
  task automatic t_pec();
    crc = crc8(crc8(crc8(8'h00, 8'h6C), 8'h14), 8'h3B);
    frame('{8'h14, 8'h3B, crc});
    u_host.start_c();
    u_host.wr_byte(8'h6C, ack);
    u_host.wr_byte(8'h15, ack);
    u_host.wr_byte(8'h4D, ack);
    u_host.wr_byte(~crc8(crc8(crc8(8'h00, 8'h6C), 8'h15), 8'h4D), ack);
    u_host.stop_c();
    check("bad check ack", 0, ack);
    frame('{8'h14});
    rx(8'h3B);
  endtask : t_pec
  task automatic t_nv();
    frame('{8'hF8, 8'h03, 8'h5A});
    check("stretch", 1, held);
    check("scl freed", 0, scl_oe);
    frame('{8'h12});
    rx(8'h77);
    frame('{8'hF8, 8'h03});
    rx(8'h5A);
  endtask : t_nv
  task automatic t_erase();
    int n;
    frame('{8'h90, 8'h04});
    frame('{8'hF8, 8'h1F});
    frame('{8'hFE});
    u_host.start_c();
    u_host.wr_byte(8'h6C, ack);
    u_host.stop_c();
    check("busy ack", 0, ack);
    check("nv busy", 1, nv_busy);
    n = 0;
    while (nv_busy !== 1'b0 && n < 999) begin
      @(posedge core_clk);
      n++;
    end
    #1.3;  // keep bus edges off the core clock edges
    check("nv idle", 0, nv_busy);
    frame('{8'hF8, 8'h1F});
    frame('{8'hFC, 8'h02, 8'hC3, 8'h96});
    frame('{8'hF8, 8'h1F});
    rx(8'hC3);
    frame('{8'hF8, 8'h20});
    rx(8'h96);
    frame('{8'hF8, 8'h03});
    rx(8'hFF);
  endtask : t_erase
  initial begin
    rstn = 1'b0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1.3;  // bus phase unrelated to the core clock
    t_addr();
    t_block();
    t_pec();
    t_nv();
    t_erase();
    final_report();
  end
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
endmodule : testbench
`default_nettype wire
